// file: src/tcb_parser.sv
// Transmit command buffer parser with AXI4-Lite slave and output FIFO.
// Assumes a same-clock AXI4-Lite master and a same-clock frame consumer.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Word FIFO with registered output stage
module tcb_fifo import tcb_pkg::*; #(
   parameter int WIDTH = $bits(tcb_item_t),
   parameter int DEPTH = TCB_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // Fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready,
   // Occupancy including the output stage
   output logic [$clog2(DEPTH)+1:0] o_level
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp; // Write pointer
      logic [AW-1:0] rp; // Read pointer
      logic [AW:0] cnt; // Words in memory
      logic ov; // Output stage full
      logic [WIDTH-1:0] od; // Output stage data
   } tcb_fst_t;
   tcb_fst_t st_r, st_nxt;
   logic [WIDTH-1:0] mem_r [DEPTH]; // Storage array
   logic push, pop;

   // Handshakes on each side
   assign o_ready = st_r.cnt < (AW+1)'(DEPTH);
   assign push = i_valid && o_ready;
   assign pop = (st_r.cnt != '0) && (!st_r.ov || i_ready);
   assign o_valid = st_r.ov;
   assign o_data = st_r.od;
   assign o_level = {1'b0, st_r.cnt} + {{(AW+1){1'b0}}, st_r.ov};

   // Pointer and output stage update
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         // Refill output stage from memory head
         st_nxt.rp = st_r.rp + 1'b1;
         st_nxt.od = mem_r[st_r.rp];
         st_nxt.ov = 1'b1;
      end else if (i_ready) begin
         st_nxt.ov = 1'b0;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '0;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   // Memory write, no reset needed for payload
   always_ff @(posedge i_clk) begin
      if (i_ce && push) begin
         mem_r[st_r.wp] <= i_data;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - Each buffer opens with two command words
// R2 - Host writes commands before payload bytes
// R3 - Two 16-bit host writes form a word
// R4 - Host supplies both commands per buffer
// R5 - Differing second command word sets error
// R6 - Tag returned in packet status
// R7 - Completion bit raises buffer-done after loading
// R8 - Host writes reserved bits as zero
// R9 - Alignment code picks 4/16/32 byte end
// R10 - End padding words are discarded
// R11 - Skipped words never enter the FIFO
// R12 - Code 11 reserved, treated as 4-byte
// R13 - Bit 13 first, bit 12 last segment
// R14 - Bits 10:0 give payload byte count
// R15 - Byte sum mismatch with length sets error
// R16 - Leading bytes before start offset skipped
module tcb_parser import tcb_pkg::*; #(
   parameter int FIFO_DEPTH = TCB_FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // AXI4-Lite write address and data
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   // AXI4-Lite write response
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Payload stream towards the transmitter
   output tcb_item_t o_tx_item,
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   // Flags
   output logic o_tx_error_flag,
   output logic o_tx_buffer_done_flag
);
   localparam int LW = $clog2(FIFO_DEPTH) + 2;
   typedef struct packed {
      tcb_phase_t phase; // Parser phase
      logic half; // Low half held
      logic [15:0] lo16; // Held low half
      logic [31:0] cmda; // Current command A
      logic [31:0] prevb; // Command B of packet
      logic [15:0] sum; // Running byte sum
      logic [9:0] wcnt; // Body word index
      logic err; // tx_error_flag
      logic done; // tx_buffer_done_flag
      logic [15:0] tag; // Last completed tag
      logic push; // FIFO push strobe
      tcb_item_t item; // Word to push
      logic wrdy; // AW and W ready
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tcb_st_t;
   tcb_st_t st_r, st_nxt;
   logic fifo_rdy;
   logic [LW-1:0] fifo_lvl;
   logic hs_w, hs_data, word_ev, fin, ls;
   logic [31:0] word;
   logic [15:0] nsum;
   logic [12:0] span;
   logic [9:0] nwords, total;
   logic [3:0] keep;
   logic [12:0] pos;

   ////////////////////////////////////////////////////////////////////////
   // Datapath helpers shared with the checks
   assign hs_w = st_r.wrdy && i_awvalid && i_wvalid;
   assign hs_data = hs_w && (i_awaddr == TCB_OFF_DATA);
   // R3 - pair half writes
   assign word_ev = hs_data && st_r.half;
   assign word = {i_wdata[15:0], st_r.lo16};
   assign ls = st_r.cmda[TCB_A_LS];
   // R14 - bytes spanned incl. offset
   assign span = 13'(st_r.cmda[TCB_A_OFS_HI:TCB_A_OFS_LO])
      + 13'(st_r.cmda[TCB_A_SIZE_HI:0]);
   assign nwords = 10'((span + 13'h0003) >> 2);

   // R9 - round word total to alignment
   always_comb begin
      unique case (st_r.cmda[TCB_A_ALN_HI:TCB_A_ALN_LO])
         TCB_ALN_16: total = (nwords + TCB_M16) & ~TCB_M16;
         TCB_ALN_32: total = (nwords + TCB_M32) & ~TCB_M32;
         // R12 - reserved code acts as 4-byte
         default: total = nwords;
      endcase
   end

   // R16 - keep only bytes inside payload window
   always_comb begin
      keep = '0;
      pos = '0;
      for (int b = 0; b < 4; b++) begin
         pos = {st_r.wcnt, 2'(b)} + 13'h0000;
         keep[b] = (pos >= 13'(st_r.cmda[TCB_A_OFS_HI:TCB_A_OFS_LO]))
            && (pos < span);
      end
   end

   // Buffer ends on last body word, or at command B for empty bodies
   assign fin = word_ev && (((st_r.phase == TCB_BODY)
      && (st_r.wcnt + 10'h001 == total))
      || ((st_r.phase == TCB_CMDB) && (total == '0)));
   // R13 - first segment restarts byte sum
   assign nsum = st_r.cmda[TCB_A_FIRST_SEGMENT_FLAG]
      ? 16'(st_r.cmda[TCB_A_SIZE_HI:0])
      : st_r.sum + 16'(st_r.cmda[TCB_A_SIZE_HI:0]);

   ////////////////////////////////////////////////////////////////////////
   // Next state: bus slave, parser and flags
   always_comb begin
      st_nxt = st_r;
      st_nxt.push = 1'b0;
      st_nxt.wrdy = 1'b0;
      // Accept write once both channels wait; data needs FIFO room
      if (!st_r.wrdy && !st_r.bvalid && i_awvalid && i_wvalid
         && (i_awaddr != TCB_OFF_DATA || (fifo_rdy && !st_r.push))) begin
         st_nxt.wrdy = 1'b1;
      end
      if (st_r.bvalid && i_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (hs_w) begin
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = (i_awaddr == TCB_OFF_DATA
            || i_awaddr == TCB_OFF_STAT) ? TCB_RESP_OK : TCB_RESP_SLVERR;
         // Clear flags written with one
         if (i_awaddr == TCB_OFF_STAT && i_wstrb[0]) begin
            if (i_wdata[TCB_ST_ERR]) begin
               st_nxt.err = 1'b0;
            end
            if (i_wdata[TCB_ST_DONE]) begin
               st_nxt.done = 1'b0;
            end
         end
      end
      if (hs_data && !st_r.half) begin
         // First half of a word is only held
         st_nxt.lo16 = i_wdata[15:0];
         st_nxt.half = 1'b1;
      end
      if (word_ev) begin
         st_nxt.half = 1'b0;
         unique case (st_r.phase)
            // R1 - first word is command A
            TCB_CMDA: begin
               st_nxt.cmda = word;
               st_nxt.phase = TCB_CMDB;
            end
            TCB_CMDB: begin
               // R5 - later segments must repeat command B
               if (!st_r.cmda[TCB_A_FIRST_SEGMENT_FLAG]
                  && word != st_r.prevb) begin
                  st_nxt.err = 1'b1;
               end
               st_nxt.prevb = word;
               st_nxt.sum = nsum;
               st_nxt.wcnt = '0;
               st_nxt.phase = (total == '0) ? TCB_CMDA : TCB_BODY;
            end
            TCB_BODY: begin
               st_nxt.wcnt = st_r.wcnt + 10'h001;
               // R11 - words without payload bytes are not stored
               // R10 - padding words carry no kept byte
               if (keep != '0) begin
                  st_nxt.push = 1'b1;
                  st_nxt.item.data = word;
                  st_nxt.item.keep = keep;
                  st_nxt.item.last = ls && ({st_r.wcnt, 2'b00}
                     + 13'h0004 >= span);
               end
               if (st_r.wcnt + 10'h001 == total) begin
                  st_nxt.phase = TCB_CMDA;
               end
            end
            default: st_nxt.phase = TCB_CMDA;
         endcase
      end
      if (fin) begin
         // R7 - completion request raises done, set wins
         if (st_r.cmda[TCB_A_IOC]) begin
            st_nxt.done = 1'b1;
         end
         if (ls) begin
            // R6 - keep tag for the packet status
            st_nxt.tag = (st_r.phase == TCB_CMDB)
               ? word[TCB_B_TAG_HI:TCB_B_TAG_LO]
               : st_r.prevb[TCB_B_TAG_HI:TCB_B_TAG_LO];
            // R15 - byte sum against packet length
            if (((st_r.phase == TCB_CMDB) ? nsum : st_r.sum)
               != 16'(st_r.prevb[TCB_B_LEN_HI:0] & {11{st_r.phase
               == TCB_BODY}} | word[TCB_B_LEN_HI:0] & {11{st_r.phase
               == TCB_CMDB}})) begin
               st_nxt.err = 1'b1;
            end
         end
      end
      // Read channel: one read at a time
      st_nxt.arrdy = !st_r.arrdy && !st_r.rvalid && i_arvalid;
      if (st_r.rvalid && i_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (st_r.arrdy && i_arvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = TCB_RESP_OK;
         unique case (i_araddr)
            TCB_OFF_STAT: st_nxt.rdata = {30'h0000_0000, st_r.done, st_r.err};
            TCB_OFF_TAG: st_nxt.rdata = {16'h0000, st_r.tag};
            TCB_OFF_LVL: st_nxt.rdata = 32'(fifo_lvl);
            TCB_OFF_DATA: st_nxt.rdata = 32'h0000_0000;
            default: begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rresp = TCB_RESP_SLVERR;
            end
         endcase
      end
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '0;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output buffer; stalls the bus when full
   tcb_fifo #(.WIDTH($bits(tcb_item_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_valid(st_r.push),
      .i_data(st_r.item),
      .o_ready(fifo_rdy),
      .o_valid(o_tx_valid),
      .o_data(o_tx_item),
      .i_ready(i_tx_ready),
      .o_level(fifo_lvl)
   );

   // Registered bus and flag outputs
   assign o_awready = st_r.wrdy;
   assign o_wready = st_r.wrdy;
   assign o_bvalid = st_r.bvalid;
   assign o_bresp = st_r.bresp;
   assign o_arready = st_r.arrdy;
   assign o_rvalid = st_r.rvalid;
   assign o_rdata = st_r.rdata;
   assign o_rresp = st_r.rresp;
   assign o_tx_error_flag = st_r.err;
   assign o_tx_buffer_done_flag = st_r.done;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n || !i_ce);

   pair_push_a: assert property (st_r.push |-> $past(word_ev)) // R3
      else $error("push without a paired word");
   cmd_order_a: assert property (word_ev && st_r.phase == TCB_CMDA // R1
      |=> st_r.phase == TCB_CMDB)
      else $error("command A not followed by command B phase");
   cmdb_diff_a: assert property (word_ev && st_r.phase == TCB_CMDB // R5
      && !st_r.cmda[TCB_A_FIRST_SEGMENT_FLAG] && word != st_r.prevb
      |=> st_r.err)
      else $error("command B mismatch not flagged");
   tag_keep_a: assert property (fin && ls && st_r.phase == TCB_BODY // R6
      |=> st_r.tag == $past(st_r.prevb[TCB_B_TAG_HI:TCB_B_TAG_LO]))
      else $error("tag not captured");
   done_set_a: assert property (fin && st_r.cmda[TCB_A_IOC] // R7
      |=> st_r.done)
      else $error("buffer done not raised");
   pad_drop_a: assert property (st_r.push |-> st_r.item.keep != '0) // R10
      else $error("empty word stored");
   body_only_a: assert property (st_r.push // R11
      |-> $past(st_r.phase) == TCB_BODY)
      else $error("command word stored");
   first_sum_a: assert property (word_ev && st_r.phase == TCB_CMDB // R13
      && st_r.cmda[TCB_A_FIRST_SEGMENT_FLAG]
      |=> st_r.sum == 16'($past(st_r.cmda[TCB_A_SIZE_HI:0])))
      else $error("first segment did not restart sum");
   len_err_a: assert property (fin && ls && st_r.phase == TCB_BODY // R15
      && st_r.sum != 16'(st_r.prevb[TCB_B_LEN_HI:0]) |=> st_r.err)
      else $error("length mismatch not flagged");
   ofs_skip_a: assert property (word_ev && st_r.phase == TCB_BODY // R16
      && st_r.wcnt == '0
      && st_r.cmda[TCB_A_OFS_HI:TCB_A_OFS_LO] >= 5'h04 |=> !st_r.push)
      else $error("word before start offset stored");
endmodule

// file: src/tcb_pkg.sv
// Package for the transmit command buffer parser.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
package tcb_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] TCB_OFF_DATA = 8'h00; // Half-word data port
   localparam logic [7:0] TCB_OFF_STAT = 8'h04; // Flags, W1C
   localparam logic [7:0] TCB_OFF_TAG = 8'h08; // Last packet tag
   localparam logic [7:0] TCB_OFF_LVL = 8'h0C; // FIFO occupancy
   // Status bit positions
   localparam int TCB_ST_ERR = 0; // tx_error_flag
   localparam int TCB_ST_DONE = 1; // tx_buffer_done_flag
   // AXI responses
   localparam logic [1:0] TCB_RESP_OK = 2'h0;
   localparam logic [1:0] TCB_RESP_SLVERR = 2'h2;
   ////////////////////////////////////////////////////////////////////////
   // Command word A fields
   localparam int TCB_A_IOC = 31; // Interrupt on completion
   localparam int TCB_A_ALN_HI = 25; // End alignment code
   localparam int TCB_A_ALN_LO = 24;
   localparam int TCB_A_OFS_HI = 20; // Data start offset
   localparam int TCB_A_OFS_LO = 16;
   localparam int TCB_A_FIRST_SEGMENT_FLAG = 13; // First buffer of packet
   localparam int TCB_A_LS = 12; // Last segment
   localparam int TCB_A_SIZE_HI = 10; // Buffer byte count
   // Command word B fields
   localparam int TCB_B_TAG_HI = 31;
   localparam int TCB_B_TAG_LO = 16;
   localparam int TCB_B_LEN_HI = 10; // Packet length
   // End alignment codes
   localparam logic [1:0] TCB_ALN_16 = 2'h1;
   localparam logic [1:0] TCB_ALN_32 = 2'h2;
   // Alignment masks in words: 16 bytes is 4 words, 32 bytes is 8 words
   localparam logic [9:0] TCB_M16 = 10'h003;
   localparam logic [9:0] TCB_M32 = 10'h007;
   localparam int TCB_FIFO_DEPTH = 32;
   ////////////////////////////////////////////////////////////////////////
   // FIFO item: payload word, byte keep mask, end of packet
   typedef struct packed {
      logic [31:0] data;
      logic [3:0] keep;
      logic last;
   } tcb_item_t;
   // Parser phase
   typedef enum logic [1:0] {TCB_CMDA, TCB_CMDB, TCB_BODY} tcb_phase_t;
endpackage

// file: sim/tcb_host_model.sv
// Host model: an AXI4-Lite master that issues single register cycles.
// Assumes a slave on the same clock; the bench calls its two tasks.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module tcb_host_model (
   // Clock
   input wire logic i_clk,
   // Write channels
   output logic [7:0] o_awaddr,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   output logic o_wvalid,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   output logic o_bready,
   // Read channels
   output logic [7:0] o_araddr,
   output logic o_arvalid,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   output logic o_rready
);
   // Idle bus at time zero
   initial begin
      {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
      {o_araddr, o_arvalid, o_rready} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge i_clk);
      {o_awaddr, o_awvalid, o_wdata, o_wstrb} <= {a, 1'b1, d, 4'hf};
      o_wvalid <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge i_clk);
         // Released lines show the inverse, never the stale value
         if (aw_p && i_awready === 1'b1) begin
            aw_p = 1'b0;
            {o_awvalid, o_awaddr} <= {1'b0, ~a};
         end
         if (w_p && i_wready === 1'b1) begin
            w_p = 1'b0;
            {o_wvalid, o_wdata} <= {1'b0, ~d};
         end
      end
      o_bready <= 1'b1;
      do @(posedge i_clk); while (i_bvalid !== 1'b1);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask
   // Single read, waits for the answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge i_clk);
      {o_araddr, o_arvalid} <= {a, 1'b1};
      do @(posedge i_clk); while (i_arready !== 1'b1);
      {o_araddr, o_arvalid, o_rready} <= {~a, 1'b0, 1'b1};
      do @(posedge i_clk); while (i_rvalid !== 1'b1);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask
endmodule

// file: sim/tcb_parser_tb.sv
// Bench for the transmit command buffer parser.
// Assumes the host model drives the register bus; this module the stream.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module tcb_parser_tb import tcb_pkg::*;;
   logic clk, arst_n, ce, tx_ready;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, tx_valid;
   logic arvalid, arready, rvalid, rready, err_f, done_f;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   tcb_item_t tx_item;
   tcb_item_t seen_q[$];
   int fails = 0;
   int samples_checked = 0;
   // Small FIFO so that a short buffer fills it
   tcb_parser #(.FIFO_DEPTH(4)) uut (.i_clk(clk), .i_arst_n(arst_n),
      .i_ce(ce), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .o_tx_item(tx_item), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
      .o_tx_error_flag(err_f), .o_tx_buffer_done_flag(done_f));
   tcb_host_model host (.i_clk(clk), .o_awaddr(awaddr),
      .o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata),
      .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
      .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
      .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
      .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid),
      .o_rready(rready));
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Collect every stream item that moves
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) seen_q.push_back(tx_item);
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(string nm, logic [36:0] seen, logic [36:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rd_chk(logic [7:0] a, logic [31:0] d, logic [1:0] r);
      logic [31:0] sd;
      logic [1:0] sr;
      host.rd(a, sd, sr);
      check("rdata", 37'(sd), 37'(d));
      check("rresp", 37'(sr), 37'(r));
   endtask
   task automatic wr_chk(logic [7:0] a, logic [31:0] d, logic [1:0] r);
      logic [1:0] sr;
      host.wr(a, d, sr);
      check("bresp", 37'(sr), 37'(r));
   endtask
   function automatic logic [31:0] mk_a(logic ioc, logic [1:0] al,
      logic [4:0] of, logic fs, logic ls, logic [10:0] sz);
      return {ioc, 5'h00, al, 3'h0, of, 2'h0, fs, ls, 1'h0, sz};
   endfunction
   function automatic logic [31:0] mk_b(logic [15:0] tg, logic [10:0] ln);
      return {tg, 5'h00, ln};
   endfunction
   task automatic send(logic [31:0] a, logic [31:0] b, int n,
                       logic [31:0] base);
      logic [31:0] w[$];
      logic [1:0] r;
      w = {a, b};
      for (int i = 0; i < n; i++) w.push_back(base + 32'(i));
      foreach (w[i]) begin
         host.wr(TCB_OFF_DATA, {16'h0000, w[i][15:0]}, r);
         host.wr(TCB_OFF_DATA, {16'h0000, w[i][31:16]}, r);
      end
   endtask
   task automatic wait_n(int n);
      for (int k = 0; k < 400 && seen_q.size() < n; k++) @(posedge clk);
   endtask
   task automatic item_chk(int i, logic [31:0] d, logic [3:0] k, logic l);
      check("item", (i < seen_q.size()) ? seen_q[i] : 37'h0, {d, k, l});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic s_reset();
      check("flags", 37'({err_f, done_f}), 37'h0);
      rd_chk(TCB_OFF_STAT, 32'h0000_0000, TCB_RESP_OK);
      rd_chk(TCB_OFF_LVL, 32'h0000_0000, TCB_RESP_OK);
      rd_chk(8'h10, 32'h0000_0000, TCB_RESP_SLVERR);
      wr_chk(TCB_OFF_TAG, 32'h0000_ffff, TCB_RESP_SLVERR);
      rd_chk(TCB_OFF_TAG, 32'h0000_0000, TCB_RESP_OK);
   endtask
   task automatic s_single();
      seen_q.delete();
      send(mk_a(1'b1, 2'h0, 5'h00, 1'b1, 1'b1, 11'h006),
           mk_b(16'habcd, 11'h006), 2, 32'h1111_0000);
      wait_n(2);
      item_chk(0, 32'h1111_0000, 4'hf, 1'b0);
      item_chk(1, 32'h1111_0001, 4'h3, 1'b1);
      rd_chk(TCB_OFF_STAT, 32'h0000_0002, TCB_RESP_OK);
      rd_chk(TCB_OFF_TAG, 32'h0000_abcd, TCB_RESP_OK);
      wr_chk(TCB_OFF_STAT, 32'h0000_0003, TCB_RESP_OK);
      rd_chk(TCB_OFF_STAT, 32'h0000_0000, TCB_RESP_OK);
   endtask
   // Each legal alignment code, then an offset inside a padded buffer
   task automatic s_align();
      int nw[4] = '{1, 4, 8, 1};
      seen_q.delete();
      for (int c = 0; c < 4; c++) begin
         send(mk_a(1'b0, (c == 3) ? 2'h0 : 2'(c), 5'h00, 1'b1, 1'b1,
              11'h004),
              mk_b(16'h0000, 11'h004), nw[c], 32'h2000_0000 + 32'(c));
      end
      send(mk_a(1'b0, TCB_ALN_16, 5'h05, 1'b1, 1'b1, 11'h003),
           mk_b(16'h0000, 11'h003), 4, 32'h3000_0000);
      wait_n(6);
      for (int c = 0; c < 4; c++) begin
         item_chk(c, 32'h2000_0000 + 32'(c), 4'hf, 1'b1);
      end
      item_chk(4, 32'h3000_0001, 4'he, 1'b1);
      check("extra items", 37'(seen_q.size()), 37'h5);
      rd_chk(TCB_OFF_STAT, 32'h0000_0000, TCB_RESP_OK);
   endtask
   // Split packets: matching, differing second command, bad length
   task automatic s_multi();
      seen_q.delete();
      for (int p = 0; p < 2; p++) begin
         send(mk_a(1'b0, 2'h0, 5'h00, 1'b1, 1'b0, 11'h004),
              mk_b(16'h5a5a, 11'h008), 1, 32'h4000_0000);
         send(mk_a(1'b0, 2'h0, 5'h00, 1'b0, 1'b1, 11'h004),
              mk_b(16'h5a5a + 16'(p), 11'h008), 1, 32'h4000_0001);
         if (p == 0) begin
            wait_n(2);
            item_chk(0, 32'h4000_0000, 4'hf, 1'b0);
            item_chk(1, 32'h4000_0001, 4'hf, 1'b1);
            check("err", 37'(err_f), 37'h0);
         end
      end
      rd_chk(TCB_OFF_STAT, 32'h0000_0001, TCB_RESP_OK);
      wr_chk(TCB_OFF_STAT, 32'h0000_0001, TCB_RESP_OK);
      send(mk_a(1'b0, 2'h0, 5'h00, 1'b1, 1'b1, 11'h004),
           mk_b(16'h0001, 11'h005), 1, 32'h5000_0000);
      rd_chk(TCB_OFF_STAT, 32'h0000_0001, TCB_RESP_OK);
      wr_chk(TCB_OFF_STAT, 32'h0000_0001, TCB_RESP_OK);
   endtask
   // Stalled consumer: FIFO fills and refuses, then drains empty
   task automatic s_fill();
      seen_q.delete();
      tx_ready <= 1'b0;
      fork
         send(mk_a(1'b0, 2'h0, 5'h00, 1'b1, 1'b1, 11'h018),
              mk_b(16'h0000, 11'h018), 6, 32'h6000_0000);
         begin
            repeat (200) @(posedge clk);
            // Four memory words plus the output stage
            rd_chk(TCB_OFF_LVL, 32'h0000_0005, TCB_RESP_OK);
            check("early", 37'(seen_q.size()), 37'h0);
            tx_ready <= 1'b1;
         end
      join
      wait_n(6);
      for (int i = 0; i < 6; i++) begin
         item_chk(i, 32'h6000_0000 + 32'(i), 4'hf, 1'(i == 5));
      end
      rd_chk(TCB_OFF_LVL, 32'h0000_0000, TCB_RESP_OK);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {arst_n, ce, tx_ready} = 3'b011;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      s_reset();
      s_single();
      s_align();
      s_multi();
      s_fill();
      wrap_up();
   end
   // Watchdog, well beyond the fewer than two thousand cycles the tests need
   initial begin
      #300_000;
      fails++;
      wrap_up();
   end
endmodule
